// ### verilog/instr_field_decode_indexing.sv
// Instruction field decoder with index modification and program address sequencing
//
// Function
// RULE1: Function code is instruction bits 29..24 and selects the operation.
// RULE2: Non-I/O instructions carry branch condition in bits 23..21.
// RULE3: I/O instructions carry a 4-bit channel selector in bits 23..20.
// RULE4: Non-I/O instructions carry operand interpretation in bits 20..18.
// RULE5: I/O instructions carry a 2-bit operand interpretation in bits 19..18.
// RULE6: Index selector is bits 17..15, picking the modifying index register.
// RULE7: Operand field is bits 14..0.
// RULE8: Effective operand is operand field plus selected index register.
// RULE9: Seven 15-bit index registers numbered one to seven.
// RULE10: Index register seven also counts repeat operations.
// RULE11: Modification touches only the held copy, never the stored word.
// RULE12: A 30-bit accumulator and a second 30-bit arithmetic register exist.
// RULE13: 30-bit hold register gets index added to low 15 bits first.
// RULE14: 15-bit program address; a jump clears it, then loads target.
// RULE15: Fetch sequentially, leaving sequence only on jump or skip.
// RULE16: I/O channels are 30-line paths, not registers. Here io_chan_out is a register loaded from the accumulator every cycle.
// RULE17: Channel selector is an octal channel number choosing the channel.
// RULE18: I/O instructions decode with I/O layout, others with general layout.
// RULE19: Index selector or branch field names the index register operated on.
// RULE20: Index selector zero adds nothing to the operand field.
`timescale 1ns/1ns
`include "instr_field_decode_consts.svh"

module instr_field_decode_indexing #(
    parameter int WORD_W = 30,
    parameter int ADDR_W = 15
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [14:0] fetch_addr,
    output logic io_chan_active,
    output logic [3:0] io_chan_sel,
    output logic [29:0] io_chan_out
);

    // Field positions are fixed by the instruction format
    if (WORD_W != 30 || ADDR_W != 15) begin : g_bad_width
        $error("instr_field_decode_indexing supports only 30-bit words and 15-bit addresses");
    end

    logic [29:0] accumulator;
    logic [29:0] second_arith_operand;
    logic [14:0] index_registers [1:7];
    logic [29:0] instruction_hold;
    logic [29:0] fetch_word;
    logic [14:0] program_address;
    logic [14:0] jump_target;
    logic repeat_active;
    instr_field_decode_pkg::pa_state_t pa_state;

    logic wr_pend;
    logic [7:0] wr_off;
    logic rd_take;
    logic [29:0] wd;
    logic wr_fetch;
    logic [2:0] in_b;
    logic [14:0] idx_val;
    logic [14:0] next_eff;

    // Decoded fields of the held instruction
    logic [5:0] dec_func;
    logic dec_io;
    logic [2:0] dec_j;
    logic [3:0] dec_chan;
    logic [2:0] dec_k;
    logic [1:0] dec_kio;
    logic [2:0] dec_b;
    logic [2:0] target_index;
    logic [31:0] decode_status;
    logic [31:0] rd_mux;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture; the write lands in the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_off <= 8'h00;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                wr_off <= haddr[7:0];
            end
        end
    end

    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wd = hwdata[29:0];
    // Fetches are ignored while a jump is being sequenced
    assign wr_fetch = wr_pend && (wr_off == `IFD_OFF_FETCH) && (pa_state == instr_field_decode_pkg::ST_RUN);

    // Index value chosen by the incoming word; selector zero adds nothing
    assign in_b = wd[`IFD_B_HI:`IFD_B_LO]; // RULE6
    assign idx_val = (in_b == 3'h0) ? 15'h0 : index_registers[in_b]; // RULE20
    assign next_eff = 15'(wd[`IFD_Y_HI:`IFD_Y_LO] + idx_val); // RULE8 RULE7

    // Field split of the held word; upper bits are never touched by indexing
    assign dec_func = instruction_hold[`IFD_F_HI:`IFD_F_LO]; // RULE1
    assign dec_io = instr_field_decode_pkg::is_io(dec_func); // RULE18
    assign dec_j = dec_io ? 3'h0 : instruction_hold[`IFD_J_HI:`IFD_J_LO]; // RULE2
    assign dec_chan = dec_io ? instruction_hold[`IFD_CH_HI:`IFD_CH_LO] : 4'h0; // RULE3
    assign dec_k = dec_io ? 3'h0 : instruction_hold[`IFD_K_HI:`IFD_K_LO]; // RULE4
    assign dec_kio = dec_io ? instruction_hold[`IFD_KIO_HI:`IFD_KIO_LO] : 2'h0; // RULE5
    assign dec_b = instruction_hold[`IFD_B_HI:`IFD_B_LO];
    // Register-class instructions name their index register in the branch field
    assign target_index = instr_field_decode_pkg::j_names_index(dec_func) ? dec_j : dec_b; // RULE19

    // Status word is exactly 32 bits; the top nibble stays zero for later fields
    assign decode_status = {4'h0, repeat_active, dec_io, 2'h0, target_index, dec_b, dec_kio,
                            dec_k, dec_chan, dec_j, dec_func};

    // Arithmetic operand registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accumulator <= `IFD_RST_WORD;
            second_arith_operand <= `IFD_RST_WORD;
        end else if (wr_pend) begin
            if (wr_off == `IFD_OFF_ACC) begin
                accumulator <= wd; // RULE12
            end
            if (wr_off == `IFD_OFF_SECOND) begin
                second_arith_operand <= wd; // RULE12
            end
        end
    end

    // Index registers one to seven; seven also steps down under repeat
    for (genvar n = 1; n <= 7; n++) begin : g_index
        localparam logic [7:0] OFF = 8'(`IFD_OFF_IDX1 + 4 * (n - 1));
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                index_registers[n] <= `IFD_RST_ADDR;
            end else if (wr_pend && wr_off == OFF) begin
                index_registers[n] <= wd[14:0]; // RULE9
            end else if (n == 7 && wr_fetch && repeat_active && index_registers[n] != 15'h0) begin
                index_registers[n] <= 15'(index_registers[n] - 15'h1); // RULE10
            end
        end
    end

    // Repeat mode ends when the count in index seven runs out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            repeat_active <= 1'b0;
        end else if (wr_fetch) begin
            if (wd[`IFD_F_HI:`IFD_F_LO] == instr_field_decode_pkg::FC_REPEAT) begin
                repeat_active <= 1'b1; // RULE10
            end else if (repeat_active) begin
                repeat_active <= (index_registers[7] > 15'h1); // RULE10
            end
        end
    end

    // Stored copy kept as fetched, held copy modified before execution
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fetch_word <= `IFD_RST_WORD;
            instruction_hold <= `IFD_RST_WORD;
        end else if (wr_fetch) begin
            fetch_word <= wd; // RULE11
            instruction_hold <= {wd[29:15], next_eff}; // RULE13
        end
    end

    // Jump target latched for the load step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            jump_target <= `IFD_RST_ADDR;
        end else if (wr_pend && wr_off == `IFD_OFF_JUMP && pa_state == instr_field_decode_pkg::ST_RUN) begin
            jump_target <= wd[14:0];
        end
    end

    // Jump sequencing: clear first, then load the new address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_state <= instr_field_decode_pkg::ST_RUN;
        end else begin
            unique case (pa_state)
                instr_field_decode_pkg::ST_RUN: begin
                    if (wr_pend && wr_off == `IFD_OFF_JUMP) begin
                        pa_state <= instr_field_decode_pkg::ST_CLR;
                    end
                end
                instr_field_decode_pkg::ST_CLR: begin
                    pa_state <= instr_field_decode_pkg::ST_LOAD;
                end
                instr_field_decode_pkg::ST_LOAD: begin
                    pa_state <= instr_field_decode_pkg::ST_RUN;
                end
                default: begin
                    pa_state <= instr_field_decode_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Program address: step per fetch, extra step on skip, clear-then-load on jump
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_address <= `IFD_RST_ADDR;
        end else begin
            unique case (pa_state)
                instr_field_decode_pkg::ST_CLR: begin
                    program_address <= 15'h0; // RULE14
                end
                instr_field_decode_pkg::ST_LOAD: begin
                    program_address <= jump_target; // RULE14
                end
                default: begin
                    if (wr_fetch) begin
                        program_address <= 15'(program_address + 15'h1); // RULE15
                    end else if (wr_pend && wr_off == `IFD_OFF_CTRL && wd[`IFD_CTRL_SKIP]) begin
                        program_address <= 15'(program_address + 15'h1); // RULE15
                    end
                end
            endcase
        end
    end

    // Channel lines registered one cycle behind from the held I/O instruction and the accumulator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_chan_active <= 1'b0;
            io_chan_sel <= 4'h0;
            io_chan_out <= `IFD_RST_WORD;
            fetch_addr <= `IFD_RST_ADDR;
        end else begin
            io_chan_active <= dec_io; // RULE18
            io_chan_sel <= dec_chan; // RULE17
            io_chan_out <= accumulator; // RULE16
            fetch_addr <= program_address; // RULE15
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            `IFD_OFF_ACC: rd_mux = {2'h0, accumulator};
            `IFD_OFF_SECOND: rd_mux = {2'h0, second_arith_operand};
            `IFD_OFF_FETCH: rd_mux = {2'h0, fetch_word};
            `IFD_OFF_HOLD: rd_mux = {2'h0, instruction_hold};
            `IFD_OFF_PADDR: rd_mux = {17'h0, program_address};
            `IFD_OFF_JUMP: rd_mux = {17'h0, jump_target};
            `IFD_OFF_DECODE: rd_mux = decode_status;
            `IFD_OFF_EFF: rd_mux = {17'h0, instruction_hold[14:0]};
            default: begin
                for (int n = 1; n <= 7; n++) begin
                    if (haddr[7:0] == 8'(`IFD_OFF_IDX1 + 4 * (n - 1))) begin
                        rd_mux = {17'h0, index_registers[n]};
                    end
                end
            end
        endcase
    end

    // Read data registered at the address phase edge, valid through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (rd_take) begin
            hrdata <= rd_mux;
        end
    end

    // Checks
    AST_FUNC_FIELD: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
        wr_fetch |=> dec_func == $past(hwdata[29:24]))
        else $error("function code not taken from bits 29..24");

    AST_OPERAND_ADD: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
        wr_fetch |=> instruction_hold[14:0] == $past(next_eff) && instruction_hold[29:15] == $past(hwdata[29:15]))
        else $error("held word not operand plus index");

    AST_ZERO_INDEX: assert property (@(posedge hclk) disable iff (!hresetn) // RULE20
        wr_fetch && hwdata[17:15] == 3'h0 |=> instruction_hold[14:0] == $past(hwdata[14:0]))
        else $error("selector zero modified the operand");

    AST_STORED_INTACT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
        wr_fetch |=> fetch_word == $past(hwdata[29:0]))
        else $error("stored copy altered");

    AST_SEQ_FETCH: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
        wr_fetch |=> program_address == 15'($past(program_address) + 15'h1))
        else $error("program address did not step");

    AST_JUMP_SEQ: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
        pa_state == instr_field_decode_pkg::ST_RUN && wr_pend && wr_off == `IFD_OFF_JUMP
        |=> ##1 program_address == 15'h0 ##1 program_address == jump_target)
        else $error("jump did not clear then load");

    AST_IO_CHANNEL: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
        dec_io |=> io_chan_active && io_chan_sel == $past(instruction_hold[23:20]))
        else $error("channel selector not driven");

    AST_TARGET_INDEX: assert property (@(posedge hclk) disable iff (!hresetn) // RULE19
        !dec_io && instr_field_decode_pkg::j_names_index(dec_func) |-> target_index == instruction_hold[23:21])
        else $error("branch field not used as index name");

    AST_REPEAT_COUNT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
        wr_fetch && repeat_active && index_registers[7] != 15'h0 && !(wr_off == `IFD_OFF_IDX7)
        |=> index_registers[7] == 15'($past(index_registers[7]) - 15'h1))
        else $error("repeat count not decremented");

    AST_GEN_LAYOUT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2 RULE4
        !dec_io |-> dec_j == instruction_hold[23:21] && dec_k == instruction_hold[20:18] && dec_chan == 4'h0)
        else $error("general layout fields misplaced");

    AST_IO_LAYOUT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3 RULE5
        dec_io |-> dec_chan == instruction_hold[23:20] && dec_kio == instruction_hold[19:18] && dec_j == 3'h0)
        else $error("I/O layout fields misplaced");

    AST_INDEX_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
        wr_pend && wr_off == `IFD_OFF_IDX1 |=> index_registers[1] == $past(hwdata[14:0]))
        else $error("index register one not written");

    // A skip only moves the address while no jump is being sequenced
    AST_SKIP_STEP: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
        pa_state == instr_field_decode_pkg::ST_RUN && wr_pend && wr_off == `IFD_OFF_CTRL && hwdata[0]
        |=> program_address == 15'($past(program_address) + 15'h1))
        else $error("skip did not step the program address");

    AST_ACC_WRITE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
        wr_pend && wr_off == `IFD_OFF_ACC |=> accumulator == $past(hwdata[29:0]))
        else $error("accumulator not written");

    COV_IO_FETCH: cover property (@(posedge hclk) disable iff (!hresetn) wr_fetch ##1 dec_io);
    COV_INDEXED: cover property (@(posedge hclk) disable iff (!hresetn) wr_fetch && hwdata[17:15] != 3'h0);
    COV_JUMP: cover property (@(posedge hclk) disable iff (!hresetn) pa_state == instr_field_decode_pkg::ST_LOAD);
    COV_REPEAT_END: cover property (@(posedge hclk) disable iff (!hresetn) repeat_active ##1 !repeat_active);

endmodule : instr_field_decode_indexing

// ### verilog/instr_field_decode_consts.svh
// Register offsets, field positions and reset values for the instruction field decoder
`ifndef INSTR_FIELD_DECODE_CONSTS_SVH
`define INSTR_FIELD_DECODE_CONSTS_SVH

// Register byte offsets (low address byte)
`define IFD_OFF_ACC      8'h00
`define IFD_OFF_SECOND   8'h04
`define IFD_OFF_FETCH    8'h08
`define IFD_OFF_HOLD     8'h0c
`define IFD_OFF_PADDR    8'h10
`define IFD_OFF_JUMP     8'h14
`define IFD_OFF_CTRL     8'h18
`define IFD_OFF_DECODE   8'h1c
`define IFD_OFF_IDX1     8'h20
`define IFD_OFF_IDX7     8'h38
`define IFD_OFF_EFF      8'h3c

// Instruction field positions
`define IFD_F_HI         29
`define IFD_F_LO         24
`define IFD_J_HI         23
`define IFD_J_LO         21
`define IFD_CH_HI        23
`define IFD_CH_LO        20
`define IFD_K_HI         20
`define IFD_K_LO         18
`define IFD_KIO_HI       19
`define IFD_KIO_LO       18
`define IFD_B_HI         17
`define IFD_B_LO         15
`define IFD_Y_HI         14
`define IFD_Y_LO         0

// Control register bit: skip the next sequential instruction
`define IFD_CTRL_SKIP    0

// Reset values
`define IFD_RST_WORD     30'h0
`define IFD_RST_ADDR     15'h0

`endif

// ### verilog/instr_field_decode_pkg.sv
// Types and opcode classes for the instruction field decoder
package instr_field_decode_pkg;

    // Jump sequencing, Gray coded along run -> clear -> load
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_CLR  = 2'b01,
        ST_LOAD = 2'b11
    } pa_state_t;

    typedef logic [5:0] func_code_t;

    localparam func_code_t FC_REPEAT = 6'h38;

    // Function codes that name a channel and use the I/O layout
    function automatic logic is_io(input func_code_t f);
        case (f)
            6'h0b, 6'h0f, 6'h32, 6'h33, 6'h36, 6'h37, 6'h3b, 6'h3c, 6'h3d, 6'h3e: is_io = 1'b1;
            default: is_io = 1'b0;
        endcase
    endfunction : is_io

    // Function codes whose branch-condition field names the index register worked on
    function automatic logic j_names_index(input func_code_t f);
        case (f)
            6'h0a, 6'h0e, 6'h39, 6'h3a: j_names_index = 1'b1;
            default: j_names_index = 1'b0;
        endcase
    endfunction : j_names_index

endpackage : instr_field_decode_pkg

// ### tb/core_store_model.sv
// Core storage model that serves instruction words by program address
`timescale 1ns/1ns

module core_store_model (
    input wire logic [14:0] addr,
    output logic [29:0] word
);
    logic [29:0] mem [0:255];

    // The block side only reads, so stored words never change
    assign word = mem[addr[7:0]];

    // Preload from the bench before a run of fetches
    task automatic load(input logic [7:0] a, input logic [29:0] w);
        mem[a] = w;
    endtask : load

    // Empty storage reads as zero words
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 30'h0;
        end
    end
endmodule : core_store_model

// ### tb/tb_top.sv
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ns
`include "instr_field_decode_consts.svh"

module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic [14:0] fetch_addr;
    wire logic io_chan_active;
    wire logic [3:0] io_chan_sel;
    wire logic [29:0] io_chan_out;
    wire logic [29:0] mem_word;
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] rv;
    logic [14:0] idx [0:7];
    logic saw_zero;
    logic [5:0] io_codes [0:9] = '{6'h0b, 6'h0f, 6'h32, 6'h33, 6'h36, 6'h37, 6'h3b, 6'h3c, 6'h3d, 6'h3e};

    always #5 hclk = ~hclk;

    instr_field_decode_indexing i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetch_addr(fetch_addr),
        .io_chan_active(io_chan_active), .io_chan_sel(io_chan_sel), .io_chan_out(io_chan_out));

    core_store_model i_mem (.addr(fetch_addr), .word(mem_word));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Address phase held until hready, then data phase until hready again
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, rv, e);
    endtask : rdc

    // Expected decode word, layout picked by the I/O class
    function automatic logic [31:0] dexp(input logic [29:0] w, input logic io, input logic jn, input logic rep);
        return {4'h0, rep, io, 2'b0, jn ? w[23:21] : w[17:15], w[17:15], io ? w[19:18] : 2'b0,
            io ? 3'b0 : w[20:18], io ? w[23:20] : 4'h0, io ? 3'b0 : w[23:21], w[29:24]};
    endfunction : dexp

    // Fetch the word at the program address and check every view of it
    task automatic fetch_chk(input logic io, input logic jn, input logic rep);
        logic [29:0] fw;
        logic [31:0] h;
        logic [14:0] pa;
        // Let the storage output settle after a fresh preload
        @(posedge hclk);
        fw = mem_word;
        h = {2'b0, fw[29:15], fw[14:0] + idx[fw[17:15]]};
        pa = fetch_addr + 15'h1;
        wr(`IFD_OFF_FETCH, {2'b0, fw});
        rdc("hold", `IFD_OFF_HOLD, h);
        rdc("eff", `IFD_OFF_EFF, {17'h0, h[14:0]});
        rdc("fetched", `IFD_OFF_FETCH, {2'b0, fw});
        rdc("decode", `IFD_OFF_DECODE, dexp(fw, io, jn, rep));
        rdc("paddr", `IFD_OFF_PADDR, {17'h0, pa});
        chk("io_active", {31'h0, io_chan_active}, {31'h0, io});
        chk("io_sel", {28'h0, io_chan_sel}, io ? {28'h0, fw[23:20]} : 32'h0);
    endtask : fetch_chk

    // Hang guard, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        finish_test();
    end

    initial begin
        for (int i = 0; i < 8; i++) begin
            idx[i] = 15'h0;
        end
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("paddr_rst", `IFD_OFF_PADDR, 32'h0);
        rdc("hold_rst", `IFD_OFF_HOLD, 32'h0);
        // Arithmetic registers keep 30 bits; channel lines follow the accumulator
        wr(`IFD_OFF_ACC, 32'hffff_ffff);
        rdc("acc", `IFD_OFF_ACC, 32'h3fff_ffff);
        chk("chan_out", {2'b0, io_chan_out}, 32'h3fff_ffff);
        wr(`IFD_OFF_SECOND, 32'hd234_5678);
        rdc("second", `IFD_OFF_SECOND, 32'h1234_5678);
        // Seven index registers, upper write bits dropped
        for (int n = 1; n < 8; n++) begin
            idx[n] = 15'(n * 32'h0fff);
            wr(8'h20 + 8'(4 * (n - 1)), {16'hffff, 1'b1, idx[n]});
        end
        for (int n = 1; n < 8; n++) begin
            rdc("index", 8'h20 + 8'(4 * (n - 1)), {17'h0, idx[n]});
        end
        // Read-only and unmapped places ignore writes
        wr(`IFD_OFF_HOLD, 32'h0000_1234);
        rdc("hold_ro", `IFD_OFF_HOLD, 32'h0);
        wr(8'h80, 32'h0000_5555);
        rdc("unmapped", 8'h80, 32'h0);
        // Skip, then jump: address drops to zero before the target
        wr(`IFD_OFF_CTRL, 32'h1);
        rdc("skip", `IFD_OFF_PADDR, 32'h1);
        saw_zero = 1'b0;
        wr(`IFD_OFF_JUMP, 32'h0000_0040);
        repeat (6) begin
            @(posedge hclk);
            #1;
            if (fetch_addr === 15'h0) saw_zero = 1'b1;
        end
        chk("jump_clear", {31'h0, saw_zero}, 32'h1);
        chk("jump_load", {17'h0, fetch_addr}, 32'h40);
        rdc("paddr_jump", `IFD_OFF_PADDR, 32'h40);
        // General layout, every index selector including zero
        for (int b = 0; b < 8; b++) begin
            i_mem.load(8'h40 + 8'(b), {6'h20, 3'(b), 3'd3, 3'(b), 15'h7ff0 + 15'(b)});
        end
        for (int i = 0; i < 10; i++) begin
            i_mem.load(8'h48 + 8'(i), {io_codes[i], 4'(i + 6), 2'(i), 3'(i % 8), 15'h0100});
        end
        i_mem.load(8'h52, {6'h0a, 3'd6, 3'd0, 3'd1, 15'h0});
        i_mem.load(8'h53, {6'h38, 24'h0});
        for (int b = 0; b < 8; b++) begin
            fetch_chk(1'b0, 1'b0, 1'b0);
        end
        // Every I/O code uses the channel layout
        for (int i = 0; i < 10; i++) begin
            fetch_chk(1'b1, 1'b0, 1'b0);
        end
        fetch_chk(1'b0, 1'b1, 1'b0);
        // Repeat counts down in index register seven
        wr(`IFD_OFF_IDX7, 32'h2);
        idx[7] = 15'h2;
        fetch_chk(1'b0, 1'b0, 1'b1);
        fetch_chk(1'b0, 1'b0, 1'b1);
        rdc("rep_count", `IFD_OFF_IDX7, 32'h1);
        fetch_chk(1'b0, 1'b0, 1'b0);
        rdc("rep_done", `IFD_OFF_IDX7, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        finish_test();
    end
endmodule : tb_top
